//--- core/aps_map.vh
`ifndef APS_MAP_VH
`define APS_MAP_VH
// Notes on behaviour
// - Characters are start, seven ASCII bits, even parity, one stop bit, NRZ.
// - Link runs at 300 to 38400 baud; timing is the UART's concern.
// - Read reply: STX, menu, parameter, data, ETX, checksum.
// - Reply data uses only needed characters, at most twelve.
// - Reply data starts with a sign; a point never leads or trails digits.
// - Missing parameter on read answers with EOT alone.
// - Checksum is XOR of menu digit through ETX; below 32 add 32.
// - Written data at most twelve characters; leading spaces only; sign optional.
// - Optional point, at most nine fraction digits; rescale to 0..7 places.
// - Reject more than ten digits or values outside signed 32-bit range.
// - Good write answers ACK; missing, out of range or malformed answers NAK.
// - Act only on own, group (second digit zero) or global zero address.
// - Group or global writes are done silently; such reads still answered.
// - Lone NAK rereads the last parameter accessed.
// - Lone ACK reads the parameter after the last one accessed.
// - Lone backspace reads the parameter before the last one accessed.
// - STX without address writes using the remembered address.
// - Short commands need a remembered address set by a completed matching command.
// - Bad address, bad digit, unequal pair, EOT, odd short or end char cancel it.
`define APS_STX        7'h02
`define APS_ETX        7'h03
`define APS_EOT        7'h04
`define APS_ENQ        7'h05
`define APS_ACK        7'h06
`define APS_BS         7'h08
`define APS_NAK        7'h15
`define APS_SPACE      7'h20
`define APS_PLUS       7'h2B
`define APS_MINUS      7'h2D
`define APS_POINT      7'h2E
`define APS_CSUM_MIN   7'h20
`define APS_MAX_CHARS  4'hC
`define APS_MAX_DIGITS 4'hA
`define APS_MAX_FRAC   4'h9
`define APS_POS_MAX    35'h07FFFFFFF
`define APS_NEG_MAX    35'h080000000
`define APS_CONV_LAST  6'h1F
`endif

//--- core/aps_fifo2.v
`timescale 1ns/10ps
module aps_fifo2 (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       inValid,
  output wire       inReady,
  input  wire [6:0] inData,
  output wire       outValid,
  input  wire       outReady,
  output wire [6:0] outData
);
  reg [6:0] mem_r [0:1];
  reg       wrPtr_r;
  reg       rdPtr_r;
  reg [1:0] cnt_r;
  wire      push;
  wire      pop;

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = mem_r[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_r[0] <= 7'h00;
      mem_r[1] <= 7'h00;
      wrPtr_r  <= 1'b0;
      rdPtr_r  <= 1'b0;
      cnt_r    <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wrPtr_r] <= inData;
        wrPtr_r        <= ~wrPtr_r;
      end
      if (pop)
        rdPtr_r <= ~rdPtr_r;
      if (push && !pop)
        cnt_r <= cnt_r + 2'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 2'h1;
    end
  end
endmodule // aps_fifo2

//--- core/aps_dec_conv.v
`timescale 1ns/10ps
`include "aps_map.vh"
module aps_dec_conv (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        start,
  input  wire [31:0] bin,
  output wire        done,
  output wire [39:0] bcd
);
  reg [31:0] sh_r;
  reg [39:0] bcd_r;
  reg [5:0]  cnt_r;
  reg        run_r;
  reg        done_r;
  reg [39:0] adj;
  integer    i;

  assign done = done_r;
  assign bcd  = bcd_r;

  // Shift-and-add-3; 32 cycles, far below one character time
  always @* begin
    adj = bcd_r;
    for (i = 0; i < 10; i = i + 1)
      if (adj[i*4 +: 4] > 4'h4)
        adj[i*4 +: 4] = adj[i*4 +: 4] + 4'h3;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_r   <= 32'h00000000;
      bcd_r  <= 40'h0000000000;
      cnt_r  <= 6'h00;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        sh_r  <= bin;
        bcd_r <= 40'h0000000000;
        cnt_r <= 6'h00;
        run_r <= 1'b1;
      end else if (run_r) begin
        bcd_r <= {adj[38:0], sh_r[31]};
        sh_r  <= {sh_r[30:0], 1'b0};
        cnt_r <= cnt_r + 6'h01;
        if (cnt_r == `APS_CONV_LAST) begin
          run_r  <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end
endmodule // aps_dec_conv

//--- core/aps_slave.v
`timescale 1ns/10ps
`include "aps_map.vh"
module aps_slave (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        rxValid,
  input  wire [6:0]  rxData,
  input  wire        rxErr,
  output wire        txValid,
  input  wire        txReady,
  output wire [6:0]  txData,
  input  wire [3:0]  devAddrHi,
  input  wire [3:0]  devAddrLo,
  output wire        parReq,
  output wire        parWe,
  output wire [6:0]  parMenu,
  output wire [6:0]  parNum,
  output wire [31:0] parWrData,
  input  wire        parAck,
  input  wire        parExists,
  input  wire [2:0]  parDp,
  input  wire [31:0] parRdData,
  input  wire        parWrOk
);
  localparam P_IDLE = 4'h0, P_IGN = 4'h1, P_A1A = 4'h2, P_A1B = 4'h3, P_A2A = 4'h4;
  localparam P_A2B = 4'h5, P_CMD = 4'h6, P_M1 = 4'h7, P_M2 = 4'h8, P_P1 = 4'h9;
  localparam P_P2 = 4'hA, P_END = 4'hB, P_DATA = 4'hC, P_CHK = 4'hD;
  localparam X_IDLE = 3'h0, X_QRY = 3'h1, X_SCALE = 3'h2, X_WR = 3'h3;
  localparam X_CONV = 3'h4, X_SEND = 3'h5, X_ONE = 3'h6;

  function isDig(input [6:0] c);
    isDig = (c >= 7'h30) && (c <= 7'h39);
  endfunction

  function [6:0] fixSum(input [6:0] s);
    fixSum = (s < `APS_CSUM_MIN) ? s + `APS_CSUM_MIN : s;
  endfunction

  function [6:0] toBin(input [3:0] hi, input [3:0] lo);
    toBin = {3'h0, hi} * 7'h0A + {3'h0, lo};
  endfunction

  // Two-digit decimal step, wrapping 99 to 00 and back
  function [7:0] bcdStep(input [7:0] v, input up);
    begin
      if (up)
        bcdStep = (v[3:0] != 4'h9) ? {v[7:4], v[3:0] + 4'h1} :
                  (v[7:4] == 4'h9) ? 8'h00 : {v[7:4] + 4'h1, 4'h0};
      else
        bcdStep = (v[3:0] != 4'h0) ? {v[7:4], v[3:0] - 4'h1} :
                  (v[7:4] == 4'h0) ? 8'h99 : {v[7:4] - 4'h1, 4'h9};
    end
  endfunction

  function [3:0] sigDigits(input [39:0] b);
    integer i;
    begin
      sigDigits = 4'h1;
      for (i = 1; i < 10; i = i + 1)
        if (b[i*4 +: 4] != 4'h0)
          sigDigits = i[3:0] + 4'h1;
    end
  endfunction

  reg [3:0]  pst_r;
  reg [2:0]  xst_r;
  reg        addrValid_r;
  reg        grp_r;
  reg        lastGrp_r;
  reg        silent_r;
  reg        isWr_r;
  reg [3:0]  dig_r;
  reg [3:0]  hiDig_r;
  reg [15:0] cur_r;
  reg [15:0] last_r;
  reg [6:0]  csum_r;
  reg [34:0] acc_r;
  reg        neg_r;
  reg        sawAny_r;
  reg        sawPt_r;
  reg        bad_r;
  reg [3:0]  nChar_r;
  reg [3:0]  nDig_r;
  reg [3:0]  frac_r;
  reg [2:0]  dp_r;
  reg [6:0]  one_r;
  reg [3:0]  phase_r;
  reg [3:0]  dIdx_r;
  reg        ptDone_r;
  reg        parReq_r;
  reg        parWe_r;
  reg [31:0] parWrData_r;
  reg [6:0]  txByte;

  wire [6:0]  c = rxData;
  wire        take = rxValid && (xst_r == X_IDLE);
  wire [34:0] accTen = acc_r * 35'h0A;
  wire        accOver = acc_r > (neg_r ? `APS_NEG_MAX : `APS_POS_MAX);
  // First digit kept apart; dig_r is reused for the second pair
  wire        fullHit = (hiDig_r == devAddrHi) && (c[3:0] == devAddrLo);
  wire        grpHit = (hiDig_r == devAddrHi) && (c[3:0] == 4'h0);
  wire        glbHit = (hiDig_r == 4'h0) && (c[3:0] == 4'h0);
  wire        convDone;
  wire [39:0] bcd;
  wire        convStart = (xst_r == X_QRY) && parAck && !isWr_r && parExists;
  wire [31:0] mag = parRdData[31] ? -parRdData : parRdData;
  wire [3:0]  sig = sigDigits(bcd);
  wire        emitPt = (dp_r != 3'h0) && (dIdx_r == {1'b0, dp_r} - 4'h1) && !ptDone_r;
  wire        inReady;
  wire        inValid = (xst_r == X_SEND) || ((xst_r == X_ONE) && !silent_r);

  assign parReq    = parReq_r;
  assign parWe     = parWe_r;
  assign parWrData = parWrData_r;
  assign parMenu   = toBin(cur_r[15:12], cur_r[11:8]);
  assign parNum    = toBin(cur_r[7:4], cur_r[3:0]);

  always @* begin
    case (phase_r)
      4'h0: txByte = `APS_STX;
      4'h1: txByte = {3'h3, cur_r[15:12]};
      4'h2: txByte = {3'h3, cur_r[11:8]};
      4'h3: txByte = {3'h3, cur_r[7:4]};
      4'h4: txByte = {3'h3, cur_r[3:0]};
      4'h5: txByte = neg_r ? `APS_MINUS : `APS_PLUS;
      4'h6: txByte = emitPt ? `APS_POINT : {3'h3, bcd[{dIdx_r, 2'b00} +: 4]};
      4'h7: txByte = `APS_ETX;
      4'h8: txByte = fixSum(csum_r);
      default: txByte = `APS_STX;
    endcase
  end

  aps_dec_conv uConv (
    .clk   (clk),
    .rst_b (rst_b),
    .start (convStart),
    .bin   (mag),
    .done  (convDone),
    .bcd   (bcd)
  );

  // Two entries keep a stalled receiver from dropping reply bytes
  aps_fifo2 uFifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (inValid),
    .inReady  (inReady),
    .inData   ((xst_r == X_ONE) ? one_r : txByte),
    .outValid (txValid),
    .outReady (txReady),
    .outData  (txData)
  );

  task launch(input wr);
    begin
      addrValid_r <= 1'b1;
      lastGrp_r   <= grp_r;
      last_r      <= cur_r;
      isWr_r      <= wr;
      silent_r    <= wr && grp_r;
      parReq_r    <= 1'b1;
      parWe_r     <= 1'b0;
      xst_r       <= X_QRY;
      pst_r       <= P_IDLE;
    end
  endtask

  task cancel;
    begin
      addrValid_r <= 1'b0;
      pst_r       <= P_IGN;
    end
  endtask

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_r <= P_IDLE;
      xst_r <= X_IDLE;
      addrValid_r <= 1'b0;
      grp_r <= 1'b0;
      lastGrp_r <= 1'b0;
      silent_r <= 1'b0;
      isWr_r <= 1'b0;
      dig_r <= 4'h0;
      hiDig_r <= 4'h0;
      cur_r <= 16'h0000;
      last_r <= 16'h0000;
      csum_r <= 7'h00;
      acc_r <= 35'h000000000;
      neg_r <= 1'b0;
      sawAny_r <= 1'b0;
      sawPt_r <= 1'b0;
      bad_r <= 1'b0;
      nChar_r <= 4'h0;
      nDig_r <= 4'h0;
      frac_r <= 4'h0;
      dp_r <= 3'h0;
      one_r <= 7'h00;
      phase_r <= 4'h0;
      dIdx_r <= 4'h0;
      ptDone_r <= 1'b0;
      parReq_r <= 1'b0;
      parWe_r <= 1'b0;
      parWrData_r <= 32'h00000000;
    end else if (take && rxErr) begin
      pst_r <= P_IGN;
    end else if (take && c == `APS_EOT) begin
      addrValid_r <= 1'b0;
      pst_r <= P_A1A;
    end else if (take) begin
      case (pst_r)
        P_IDLE: begin
          if (addrValid_r && (c == `APS_NAK || c == `APS_ACK || c == `APS_BS)) begin
            grp_r <= lastGrp_r;
            launch(1'b0);
            if (c != `APS_NAK) begin
              // Menu digits stay; only the parameter number steps
              cur_r  <= {last_r[15:8], bcdStep(last_r[7:0], c == `APS_ACK)};
              last_r <= {last_r[15:8], bcdStep(last_r[7:0], c == `APS_ACK)};
            end else
              cur_r <= last_r;
          end else if (addrValid_r && c == `APS_STX) begin
            grp_r <= lastGrp_r;
            isWr_r <= 1'b1;
            pst_r <= P_M1;
          end else
            addrValid_r <= 1'b0;
        end
        P_IGN: pst_r <= P_IGN;
        P_A1A, P_A2A: begin
          dig_r <= c[3:0];
          if (isDig(c))
            pst_r <= pst_r + 4'h1;
          else
            cancel;
        end
        P_A1B: begin
          if (isDig(c) && c[3:0] == dig_r) begin
            hiDig_r <= dig_r;
            pst_r   <= P_A2A;
          end else
            cancel;
        end
        P_A2B: begin
          if (isDig(c) && c[3:0] == dig_r && (fullHit || grpHit || glbHit)) begin
            grp_r <= !fullHit;
            pst_r <= P_CMD;
          end else
            cancel;
        end
        P_CMD: begin
          if (isDig(c)) begin
            cur_r[15:12] <= c[3:0];
            isWr_r <= 1'b0;
            pst_r <= P_M2;
          end else if (c == `APS_STX) begin
            isWr_r <= 1'b1;
            pst_r <= P_M1;
          end else
            cancel;
        end
        P_M1, P_M2, P_P1, P_P2: begin
          csum_r <= (pst_r == P_M1) ? c : csum_r ^ c;
          if (!isDig(c))
            cancel;
          else begin
            case (pst_r)
              P_M1: cur_r[15:12] <= c[3:0];
              P_M2: cur_r[11:8] <= c[3:0];
              P_P1: cur_r[7:4] <= c[3:0];
              default: cur_r[3:0] <= c[3:0];
            endcase
            pst_r <= (pst_r != P_P2) ? pst_r + 4'h1 : (isWr_r ? P_DATA : P_END);
          end
          acc_r <= 35'h000000000;
          {neg_r, sawAny_r, sawPt_r, bad_r} <= 4'h0;
          {nChar_r, nDig_r, frac_r} <= 12'h000;
        end
        P_END: begin
          if (c == `APS_ENQ)
            launch(1'b0);
          else begin
            addrValid_r <= 1'b0;
            pst_r <= P_IDLE;
          end
        end
        P_DATA: begin
          csum_r <= csum_r ^ c;
          if (c == `APS_ETX)
            pst_r <= P_CHK;
          else begin
            nChar_r <= nChar_r + 4'h1;
            if (nChar_r >= `APS_MAX_CHARS)
              bad_r <= 1'b1;
            if (c == `APS_SPACE) begin
              if (sawAny_r)
                bad_r <= 1'b1;
            end else begin
              sawAny_r <= 1'b1;
              if (c == `APS_PLUS || c == `APS_MINUS) begin
                if (sawAny_r)
                  bad_r <= 1'b1;
                neg_r <= (c == `APS_MINUS);
              end else if (c == `APS_POINT) begin
                if (sawPt_r)
                  bad_r <= 1'b1;
                sawPt_r <= 1'b1;
              end else if (isDig(c)) begin
                if (nDig_r >= `APS_MAX_DIGITS)
                  bad_r <= 1'b1;
                else
                  nDig_r <= nDig_r + 4'h1;
                acc_r <= accTen + {31'h0, c[3:0]};
                if (sawPt_r) begin
                  if (frac_r >= `APS_MAX_FRAC)
                    bad_r <= 1'b1;
                  else
                    frac_r <= frac_r + 4'h1;
                end
              end else
                bad_r <= 1'b1;
            end
          end
        end
        P_CHK: begin
          // A bad checksum is treated as a malformed frame
          if (c != fixSum(csum_r) || nDig_r == 4'h0)
            bad_r <= 1'b1;
          launch(1'b1);
        end
        default: pst_r <= P_IDLE;
      endcase
    end else begin
      case (xst_r)
        X_QRY: if (parAck) begin
          parReq_r <= 1'b0;
          dp_r <= parDp;
          if (!isWr_r) begin
            neg_r <= parRdData[31];
            if (parExists)
              xst_r <= X_CONV;
            else begin
              one_r <= `APS_EOT;
              xst_r <= X_ONE;
            end
          end else if (!parExists || bad_r || accOver) begin
            one_r <= `APS_NAK;
            xst_r <= X_ONE;
          end else
            xst_r <= X_SCALE;
        end
        X_SCALE: begin
          if (frac_r > {1'b0, dp_r}) begin
            acc_r <= acc_r / 35'h0A;
            frac_r <= frac_r - 4'h1;
          end else if (frac_r < {1'b0, dp_r}) begin
            if (accTen > `APS_NEG_MAX) begin
              one_r <= `APS_NAK;
              xst_r <= X_ONE;
            end else begin
              acc_r <= accTen;
              frac_r <= frac_r + 4'h1;
            end
          end else if (accOver) begin
            one_r <= `APS_NAK;
            xst_r <= X_ONE;
          end else begin
            parWrData_r <= neg_r ? -acc_r[31:0] : acc_r[31:0];
            parWe_r <= 1'b1;
            parReq_r <= 1'b1;
            xst_r <= X_WR;
          end
        end
        X_WR: if (parAck) begin
          parReq_r <= 1'b0;
          parWe_r <= 1'b0;
          one_r <= parWrOk ? `APS_ACK : `APS_NAK;
          xst_r <= X_ONE;
        end
        X_CONV: if (convDone) begin
          // Keep at least dp+1 digits so a point never leads
          dIdx_r <= (sig > {1'b0, dp_r}) ? sig - 4'h1 : {1'b0, dp_r};
          phase_r <= 4'h0;
          ptDone_r <= 1'b0;
          xst_r <= X_SEND;
        end
        X_SEND: if (inReady) begin
          csum_r <= (phase_r == 4'h0) ? 7'h00 : csum_r ^ txByte;
          case (phase_r)
            4'h6: begin
              if (emitPt)
                ptDone_r <= 1'b1;
              else if (dIdx_r == 4'h0)
                phase_r <= 4'h7;
              else
                dIdx_r <= dIdx_r - 4'h1;
            end
            4'h8: xst_r <= X_IDLE;
            default: phase_r <= phase_r + 4'h1;
          endcase
        end
        X_ONE: if (silent_r || inReady)
          xst_r <= X_IDLE;
        default: xst_r <= X_IDLE;
      endcase
    end
  end
endmodule // aps_slave

//--- bench/aps_slave_monitor.sv
`timescale 1ns/10ps
module aps_slave_monitor (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       rxValid,
  input wire logic       rxErr,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [6:0] txData,
  input wire logic       parReq,
  input wire logic       parWe,
  input wire logic [6:0] parMenu,
  input wire logic [6:0] parNum,
  input wire logic       parAck,
  input wire logic       parExists
);
  logic [13:0] qryId_r;

  // Last queried parameter, to pair a write with its query
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      qryId_r <= 14'h0000;
    else if (parReq && parAck && !parWe)
      qryId_r <= {parMenu, parNum};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sReqWait;
    parReq && !parAck;
  endsequence
  sequence sStoreDone;
    parReq && parAck ##1 !parReq;
  endsequence

  chk_req_hold: assert property (sReqWait |=> parReq && $stable(parMenu) && $stable(parNum))
    else $error("store request changed before ack");
  chk_req_drop: assert property (parReq && parAck |-> sStoreDone)
    else $error("store request held after ack");
  chk_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte lost under stall");
  chk_reset_idle: assert property ($rose(rst_b) |-> !txValid && !parReq && !parWe)
    else $error("activity right after reset");
  chk_reply_after: assert property ($rose(txValid) |-> !parReq)
    else $error("reply began while store busy");
  chk_write_same: assert property ($rose(parReq) && parWe |-> {parMenu, parNum} == qryId_r)
    else $error("write to a parameter not queried");
  chk_digit_range: assert property (parReq |-> parMenu <= 7'h63 && parNum <= 7'h63)
    else $error("menu or parameter above 99");
  chk_err_silent: assert property (rxValid && rxErr && !parReq && !txValid |=> !parReq [*4])
    else $error("store queried after a bad character");
  chk_ack_answer: assert property (parAck && parReq && !parWe && parExists
    |-> ##[1:100] (txValid || (parReq && parWe)))
    else $error("no follow-up after store answer");
endmodule // aps_slave_monitor

bind aps_slave aps_slave_monitor i_mon (.*);

//--- bench/aps_store_model.sv
`timescale 1ns/10ps
module aps_store_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        slow,
  input  wire logic        parReq,
  input  wire logic        parWe,
  input  wire logic [6:0]  parMenu,
  input  wire logic [6:0]  parNum,
  input  wire logic [31:0] parWrData,
  output logic             parAck,
  output logic             parExists,
  output logic [2:0]       parDp,
  output logic [31:0]      parRdData,
  output logic             parWrOk
);
  logic [31:0] mem [0:99];
  int          cnt;
  wire         hit = (parMenu == 7'h01) && (parNum != 7'h32);
  // Parameter range is narrower than the 32-bit field
  wire         inRange = $signed(parWrData) <= 1000000 && $signed(parWrData) >= -1000000;

  initial begin
    foreach (mem[i]) mem[i] = 32'h00000000;
    mem[12] = -34578;
    mem[13] = 32'h00000007;
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      parAck <= 1'b0;
      parExists <= 1'b0;
      parDp <= 3'h0;
      parRdData <= 32'h00000000;
      parWrOk <= 1'b0;
      cnt <= 0;
    end else begin
      parAck <= 1'b0;
      parRdData <= ~parRdData;
      if (parReq && !parAck) begin
        if (cnt < (slow ? 5 : 0))
          cnt <= cnt + 1;
        else begin
          cnt <= 0;
          parAck <= 1'b1;
          parExists <= hit;
          parDp <= (parNum == 7'h0C) ? 3'h2 : 3'h0;
          parRdData <= mem[parNum];
          parWrOk <= inRange;
          if (parWe && hit && inRange)
            mem[parNum] <= parWrData;
        end
      end
    end
  end
endmodule // aps_store_model

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic        clk, rst_b, rxValid, rxErr, txValid, txReady, slow;
  logic        parReq, parWe, parAck, parExists, parWrOk;
  logic [6:0]  rxData, txData, parMenu, parNum;
  logic [3:0]  devAddrHi, devAddrLo;
  logic [2:0]  parDp;
  logic [31:0] parWrData, parRdData;
  int          num_errors, n_compared;
  byte         rq[$];
  string       p = "\0041122";
  string       r12;

  aps_slave i_dut (.*);
  aps_store_model i_store (.*);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk)
    if (txValid === 1'b1 && txReady) rq.push_back({1'b0, txData});

  function automatic string ck(string b);
    byte   c;
    string r;
    c = 8'h00;
    r = " ";
    for (int i = 0; i < b.len(); i++) c = c ^ b[i];
    if (c < 8'h20) c = c + 8'h20;
    r[0] = c;
    return r;
  endfunction
  function automatic string rd(string b);
    return {"\002", b, ck(b)};
  endfunction
  function automatic string wr(string a, string b);
    return {a, "\002", b, ck(b)};
  endfunction

  // Send one command, then expect exactly the reply bytes in e
  task automatic cmd(string s, string e, int errAt = -1, bit stall = 0);
    int t;
    rq.delete();
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rxValid = 1'b1;
      rxData = 7'(s[i]);
      rxErr = (i == errAt);
    end
    @(negedge clk);
    rxValid = 1'b0;
    rxErr = 1'b0;
    if (stall) begin
      txReady = 1'b0;
      repeat (80) @(negedge clk);
      txReady = 1'b1;
    end
    t = 0;
    while (rq.size() < e.len() && t < 3000) begin
      @(negedge clk);
      t++;
    end
    // Store may still be busy with a silent write
    repeat (200) @(negedge clk);
    n_compared++;
    if (rq.size() != e.len()) begin
      num_errors++;
      $display("[FAIL] %0t length got %h exp %h", $time, rq.size(), e.len());
    end else
      foreach (rq[i]) begin
        n_compared++;
        if (rq[i] !== e[i]) begin
          num_errors++;
          $display("[FAIL] %0t byte got %h exp %h", $time, rq[i], e[i]);
        end
      end
  endtask

  task t_read;
    cmd({p, "0112\005"}, r12, -1, 1);
    cmd({p, "0111\005"}, rd("0111+0\003"));
  endtask

  task t_short;
    cmd({p, "0150\005"}, "\004");
    cmd("\010", rd("0149+0\003"));
    cmd({p, "0100\005"}, rd("0100+0\003"));
    cmd("\010", rd("0199+0\003"));
    cmd({p, "0112\005"}, r12);
    cmd("\006", rd("0113+7\003"));
    cmd("\025", rd("0113+7\003"));
    cmd("\010", r12);
  endtask

  task t_cancel;
    string bad[5];
    bad = '{"\004", "\0041123\0060112\005", {p, "0a12\005"}, "Z", {p, "0112X"}};
    foreach (bad[k]) begin
      cmd({p, "0112\005"}, r12);
      cmd(bad[k], "");
      cmd("\025", "");
    end
  endtask

  task t_err;
    cmd({p, "0112\005"}, "", 3);
    cmd({"\0041", p, "0112\005"}, r12);
  endtask

  task t_write;
    slow = 1'b1;
    cmd(wr(p, "0112+1.2345\003"), "\006");
    cmd("\025", rd("0112+1.23\003"));
    cmd(wr(p, "0113  -42\003"), "\006");
    cmd("\025", rd("0113-42\003"));
    slow = 1'b0;
  endtask

  task t_reject;
    string bad[7];
    bad = '{"0150+1\003", "011312345678901\003", "01132147483648\003", "0113+ 5\003",
            "0113+2000000\003", "0113.1234567890\003", "0113+\003"};
    foreach (bad[k]) cmd(wr(p, bad[k]), "\025");
    cmd("\025", rd("0113-42\003"));
  endtask

  task t_group;
    cmd(wr("\0041100", "0113+9\003"), "");
    cmd(wr("\0040000", "0113+8\003"), "");
    cmd({"\0040000", "0113\005"}, rd("0113+8\003"));
    cmd({"\0043344", "0113\005"}, "");
    cmd("\025", "");
    cmd({p, "0113\005"}, rd("0113+8\003"));
    cmd(rd("0113+3\003"), "\006");
    cmd("\025", rd("0113+3\003"));
  endtask

  task finish_test;
    $display("Errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    rxValid = 1'b0;
    rxData = 7'h00;
    rxErr = 1'b0;
    txReady = 1'b1;
    slow = 1'b0;
    devAddrHi = 4'h1;
    devAddrLo = 4'h2;
    num_errors = 0;
    n_compared = 0;
    r12 = rd("0112-345.78\003");
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    t_read();
    t_short();
    t_cancel();
    t_err();
    t_write();
    t_reject();
    t_group();
    finish_test();
  end
endmodule // testbench
